// *** rtl/kpi_top.sv ***
// Key pin interrupt unit: registers, event flag, interrupt and wake
// Notes on behaviour
// - up to eight key inputs, each enabled alone, one shared interrupt.
// - falling polarity: high one cycle then low the next is an edge.
// - rising polarity: low one cycle then high the next is an edge.
// - after an edge, all enabled pins must deassert before another edge.
// - mode bit 0 selects edges only or edges plus levels.
// - polarity bit per pin: 0 falling/low, 1 rising/high.
// - pin enable 0 ignores the pin, 1 lets it take part.
// - a valid edge or level sets read-only flag bit 3.
// - interrupt request while flag set and enable bit 1 set.
// - writing 1 to acknowledge bit 2 clears the flag; it stores nothing.
// - in level mode the flag stays set while any enabled pin asserted.
// - bits 7 to 4 of status/control read as zero.
// - detection continues in low power; enabled event wakes when enabled.
`default_nettype none
module kpi_top #(
    parameter int NPINS = kpi_pkg::NPINS
) (
    input  wire logic                   pclk,          // Bus clock, 50 MHz
    input  wire logic                   presetn,       // Async reset, active low
    input  wire logic                   psel,          // APB select
    input  wire logic                   penable,       // APB access phase
    input  wire logic                   pwrite,        // APB direction
    input  wire logic [kpi_pkg::AW-1:0] paddr,         // APB byte address
    input  wire logic [31:0]            pwdata,        // APB write data
    output logic      [31:0]            prdata,        // APB read data
    output logic                        pready,        // APB ready
    output logic                        pslverr,       // APB error
    input  wire logic [NPINS-1:0]       key_input_pin, // Raw key pins
    output logic                        irq_o,         // Interrupt, active high
    output logic                        wake_o         // Wake request
);
    logic [9:0]       idx;
    logic             wr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
    logic [NPINS-1:0] lvl_v;
    logic [NPINS-1:0] edge_v;
    logic             armed_v;

    logic             mode_q;
    logic             ie_q;
    logic             flag_q;
    logic [NPINS-1:0] pe_q;
    logic [NPINS-1:0] es_q;
    logic [NPINS-1:0] psts_q;
    logic [NPINS-1:0] pmsk_q;
    logic             irq_q;
    logic             wake_q;

    logic             wr_sc;
    logic             ack_w;
    logic [NPINS-1:0] pin_ev;
    logic             ev_any;
    logic             any_lvl;

    kpi_apb_slave u_apb (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .rdata_i (rdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .idx_o   (idx),
        .wr_o    (wr),
        .wdata_o (wdata)
    );

    kpi_detect #(
        .NPINS (NPINS)
    ) u_det (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_i   (key_input_pin),
        .en_i    (pe_q),
        .pol_i   (es_q),
        .lvl_o   (lvl_v),
        .edge_o  (edge_v),
        .armed_o (armed_v)
    );

    assign wr_sc   = wr && (idx == kpi_pkg::IDX_SC);
    assign ack_w   = wr_sc && wdata[kpi_pkg::BIT_ACK];
    assign any_lvl = (lvl_v != '0);

    // levels count only in level mode
    assign pin_ev = (armed_v ? edge_v : '0) | (mode_q ? lvl_v : '0);
    assign ev_any = (pin_ev != '0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= kpi_pkg::RST_SC[kpi_pkg::BIT_MODE];
            ie_q   <= kpi_pkg::RST_SC[kpi_pkg::BIT_IE];
        end else if (wr_sc) begin
            mode_q <= wdata[kpi_pkg::BIT_MODE];
            ie_q   <= wdata[kpi_pkg::BIT_IE];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pe_q <= kpi_pkg::RST_PE[NPINS-1:0];
        end else if (wr && (idx == kpi_pkg::IDX_PE)) begin
            pe_q <= wdata[NPINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            es_q <= kpi_pkg::RST_ES[NPINS-1:0];
        end else if (wr && (idx == kpi_pkg::IDX_ES)) begin
            es_q <= wdata[NPINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pmsk_q <= kpi_pkg::RST_PMSK[NPINS-1:0];
        end else if (wr && (idx == kpi_pkg::IDX_PMSK)) begin
            pmsk_q <= wdata[NPINS-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (ev_any) begin
            flag_q <= 1'b1;
        end else if (ack_w && !(mode_q && any_lvl)) begin
            flag_q <= 1'b0;
        end
    end

    // Per-pin sticky capture, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psts_q <= '0;
        end else if (wr && (idx == kpi_pkg::IDX_PSTS)) begin
            psts_q <= (psts_q & ~wdata[NPINS-1:0]) | pin_ev;
        end else begin
            psts_q <= psts_q | pin_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (flag_q && ie_q) || ((psts_q & pmsk_q) != '0);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= ie_q && (flag_q || ev_any);
        end
    end

    assign irq_o  = irq_q;
    assign wake_o = wake_q;

    always_comb begin
        rdata = 8'h00;
        if (idx == kpi_pkg::IDX_SC) begin
            rdata[kpi_pkg::BIT_MODE] = mode_q;
            rdata[kpi_pkg::BIT_IE]   = ie_q;
            rdata[kpi_pkg::BIT_FLAG] = flag_q;
        end else if (idx == kpi_pkg::IDX_PE) begin
            rdata = 8'(pe_q);
        end else if (idx == kpi_pkg::IDX_ES) begin
            rdata = 8'(es_q);
        end else if (idx == kpi_pkg::IDX_PSTS) begin
            rdata = 8'(psts_q);
        end else if (idx == kpi_pkg::IDX_PMSK) begin
            rdata = 8'(pmsk_q);
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_fall_edge_flag: assert property (
        (pe_q == 1 && !es_q[0] && armed_v && !any_lvl && $fell(key_input_pin[0]))
        ##1 (pe_q == 1 && !es_q[0]) [*2] |-> ##1 flag_q
    ) else $error("falling edge did not set flag");

    a_rise_edge_flag: assert property (
        (pe_q == 1 && es_q[0] && armed_v && !any_lvl && $rose(key_input_pin[0]))
        ##1 (pe_q == 1 && es_q[0]) [*2] |-> ##1 flag_q
    ) else $error("rising edge did not set flag");

    a_rearm_clean: assert property (
        $rose(armed_v) |-> $past(lvl_v) == '0
    ) else $error("edge detection rearmed while a pin asserted");

    a_locked_quiet: assert property (
        !armed_v && !mode_q && !flag_q |=> !flag_q
    ) else $error("flag set while edge detection locked");

    a_edge_mode_only: assert property (
        !mode_q && any_lvl && edge_v == '0 && !flag_q |=> !flag_q
    ) else $error("level set flag in edge-only mode");

    a_disabled_pins: assert property (
        pe_q == '0 |-> !ev_any
    ) else $error("event with no pin enabled");

    a_flag_readonly: assert property (
        wr_sc && wdata[kpi_pkg::BIT_FLAG] && !flag_q && !ev_any |=> !flag_q
    ) else $error("write set the event flag");

    a_irq_gate: assert property (
        flag_q && ie_q |=> irq_o
    ) else $error("interrupt missing with flag and enable set");

    a_irq_masked: assert property (
        !ie_q && (psts_q & pmsk_q) == '0 |=> !irq_o
    ) else $error("interrupt raised while masked");

    a_ack_clears: assert property (
        ack_w && !ev_any |=> !flag_q
    ) else $error("acknowledge did not clear flag");

    a_level_holds: assert property (
        ack_w && mode_q && any_lvl |=> flag_q
    ) else $error("flag cleared while level asserted");

    a_rsvd_zero: assert property (
        psel && !penable && !pwrite && paddr == {kpi_pkg::IDX_SC, 2'b00}
        |=> prdata[7:4] == 4'h0
    ) else $error("reserved status bits read nonzero");

    a_wake_req: assert property (
        flag_q && ie_q |=> wake_o
    ) else $error("wake missing with flag and enable set");

    a_set_wins: assert property (
        ack_w && ev_any |=> flag_q
    ) else $error("event lost at acknowledge");

    a_shared_source: assert property (
        armed_v && edge_v != '0 |-> ev_any
    ) else $error("pin edge did not reach the shared source");

    a_edge_locks: assert property (
        armed_v && edge_v != '0 |=> !armed_v
    ) else $error("edge detection stayed armed after an edge");

    a_locked_hold: assert property (
        !armed_v && any_lvl |=> !armed_v
    ) else $error("edge detection rearmed with a pin asserted");

    a_level_sets: assert property (
        mode_q && any_lvl |=> flag_q
    ) else $error("asserted level did not set flag in level mode");

    a_pol_rise: assert property (
        (pe_q[0] && es_q[0] && key_input_pin[0]) [*3] |-> lvl_v[0]
    ) else $error("high pin not asserted with rising polarity");

    a_pol_fall: assert property (
        (pe_q[0] && !es_q[0] && !key_input_pin[0]) [*3] |-> lvl_v[0]
    ) else $error("low pin not asserted with falling polarity");

    a_pin_ignored: assert property (
        !pe_q[0] |-> !lvl_v[0] && !edge_v[0]
    ) else $error("disabled pin reported activity");

    a_edge_sets: assert property (
        armed_v && edge_v != '0 |=> flag_q
    ) else $error("armed edge did not set flag");

    a_flag_needs_ev: assert property (
        !flag_q && !ev_any |=> !flag_q
    ) else $error("flag set without an event");

    a_flag_hold: assert property (
        !ev_any && !ack_w |=> $stable(flag_q)
    ) else $error("flag changed without event or acknowledge");

    a_ack_no_store: assert property (
        psel && !penable && !pwrite && paddr == {kpi_pkg::IDX_SC, 2'b00} |=> !prdata[kpi_pkg::BIT_ACK]
    ) else $error("acknowledge bit read back as one");

    a_irq_drop: assert property (
        !flag_q && (psts_q & pmsk_q) == '0 |=> !irq_o
    ) else $error("interrupt raised with no source set");

    a_wake_masked: assert property (
        !ie_q |=> !wake_o
    ) else $error("wake raised while interrupt disabled");

    a_wake_event: assert property (
        ie_q && ev_any |=> wake_o
    ) else $error("wake missing after enabled event");

    c_edge_event: cover property (armed_v && edge_v != '0 ##1 flag_q);
    c_level_hold: cover property (ack_w && mode_q && any_lvl ##1 flag_q);
    c_collision:  cover property (ack_w && ev_any);
    c_irq_raise:  cover property ($rose(irq_o));
    c_rearm:      cover property ($rose(armed_v));
endmodule
`default_nettype wire

// *** rtl/kpi_pkg.sv ***
// Constants and types of the key pin interrupt block
`default_nettype none
package kpi_pkg;
    localparam int         NPINS     = 8;
    localparam int         AW        = 12;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_SC    = 10'h07c;
    localparam logic [9:0] IDX_PE    = 10'h07d;
    localparam logic [9:0] IDX_ES    = 10'h07e;
    localparam logic [9:0] IDX_PSTS  = 10'h07f;
    localparam logic [9:0] IDX_PMSK  = 10'h080;
    // Field positions of key_status_control
    localparam int         BIT_MODE  = 0;
    localparam int         BIT_IE    = 1;
    localparam int         BIT_ACK   = 2;
    localparam int         BIT_FLAG  = 3;
    // Reset values
    localparam logic [7:0] RST_SC    = 8'h00;
    localparam logic [7:0] RST_PE    = 8'h00;
    localparam logic [7:0] RST_ES    = 8'h00;
    localparam logic [7:0] RST_PMSK  = 8'h00;
    typedef enum logic [1:0] {
        KPI_LOCKED = 2'b01,
        KPI_ARMED  = 2'b10
    } kpi_arm_e;
endpackage
`default_nettype wire

// *** rtl/kpi_detect.sv ***
// Pin synchroniser, polarity qualification and rearm lockout
`default_nettype none
module kpi_detect #(
    parameter int NPINS = kpi_pkg::NPINS
) (
    input  wire logic             pclk,    // Bus clock
    input  wire logic             presetn, // Async reset, active low
    input  wire logic [NPINS-1:0] pin_i,   // Raw key input pins
    input  wire logic [NPINS-1:0] en_i,    // Per-pin enable
    input  wire logic [NPINS-1:0] pol_i,   // Per-pin polarity, 1 = rising/high
    output logic      [NPINS-1:0] lvl_o,   // Enabled pin at asserted level
    output logic      [NPINS-1:0] edge_o,  // Enabled pin just became asserted
    output logic                  armed_o  // Edge detection armed
);
    logic [NPINS-1:0]  meta_q;
    logic [NPINS-1:0]  sync_q;
    logic [NPINS-1:0]  prev_q;
    logic [NPINS-1:0]  act;
    logic [NPINS-1:0]  act_prev;
    kpi_pkg::kpi_arm_e arm_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    genvar g;
    for (g = 0; g < NPINS; g++) begin : g_pin
        assign act[g]      = pol_i[g] ? sync_q[g] : ~sync_q[g];
        assign act_prev[g] = pol_i[g] ? prev_q[g] : ~prev_q[g];
    end

    assign lvl_o   = en_i & act;
    assign edge_o  = en_i & act & ~act_prev;
    assign armed_o = (arm_q == kpi_pkg::KPI_ARMED);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arm_q <= kpi_pkg::KPI_LOCKED;
        end else begin
            case (arm_q)
                kpi_pkg::KPI_LOCKED: begin
                    if (lvl_o == '0) begin
                        arm_q <= kpi_pkg::KPI_ARMED;
                    end
                end
                kpi_pkg::KPI_ARMED: begin
                    if (edge_o != '0) begin
                        arm_q <= kpi_pkg::KPI_LOCKED;
                    end
                end
                default: begin
                    arm_q <= kpi_pkg::KPI_LOCKED;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/kpi_apb_slave.sv ***
// APB slave front end with address decode and read capture
`default_nettype none
module kpi_apb_slave (
    input  wire logic                   pclk,    // Bus clock
    input  wire logic                   presetn, // Async reset, active low
    input  wire logic                   psel,    // APB select
    input  wire logic                   penable, // APB access phase
    input  wire logic                   pwrite,  // APB direction
    input  wire logic [kpi_pkg::AW-1:0] paddr,   // APB byte address
    input  wire logic [31:0]            pwdata,  // APB write data
    input  wire logic [7:0]             rdata_i, // Register read value
    output logic      [31:0]            prdata,  // APB read data
    output logic                        pready,  // APB ready
    output logic                        pslverr, // APB error
    output logic      [9:0]             idx_o,   // Register index
    output logic                        wr_o,    // Write strobe
    output logic      [7:0]             wdata_o  // Write byte
);
    logic mapped;

    assign idx_o   = paddr[kpi_pkg::AW-1:2];
    assign wdata_o = pwdata[7:0];

    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (idx_o == kpi_pkg::IDX_SC) begin
            mapped = 1'b1;
        end else if (idx_o == kpi_pkg::IDX_PE) begin
            mapped = 1'b1;
        end else if (idx_o == kpi_pkg::IDX_ES) begin
            mapped = 1'b1;
        end else if (idx_o == kpi_pkg::IDX_PSTS) begin
            mapped = 1'b1;
        end else if (idx_o == kpi_pkg::IDX_PMSK) begin
            mapped = 1'b1;
        end
    end

    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_o    = psel & penable & pwrite & mapped;

    // Read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= mapped ? {24'h00_0000, rdata_i} : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// *** dv/kpi_keys.sv ***
// Key switch model that drives the key input pins
`default_nettype none
module kpi_keys (
    input  wire logic       pclk,  // Bus clock
    input  wire logic [7:0] press, // Key held down, one bit a pin
    input  wire logic [7:0] pol,   // Asserted level of each pin
    input  wire logic       slow,  // Switch closes two cycles late
    output logic      [7:0] pin    // Pin levels seen by the block
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] d1_q;
    logic [7:0] d2_q;

    always_ff @(posedge pclk) begin
        d1_q <= press;
        d2_q <= d1_q;
    end

    assign pin = ~((slow ? d2_q : press) ^ pol);
endmodule
`default_nettype wire

// *** dv/keypad_pin_interrupt_tb.sv ***
// Self-checking bench for the key pin interrupt unit
`default_nettype none
module keypad_pin_interrupt_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] A_SC  = {kpi_pkg::IDX_SC, 2'b00};
    localparam logic [11:0] A_PE  = {kpi_pkg::IDX_PE, 2'b00};
    localparam logic [11:0] A_ES  = {kpi_pkg::IDX_ES, 2'b00};
    localparam logic [11:0] A_ST  = {kpi_pkg::IDX_PSTS, 2'b00};
    localparam logic [11:0] A_MK  = {kpi_pkg::IDX_PMSK, 2'b00};
    localparam logic [7:0]  M_ACK = 8'h01 << kpi_pkg::BIT_ACK;
    localparam logic [7:0]  M_IE  = 8'h01 << kpi_pkg::BIT_IE;
    localparam int          LIMIT = 5000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_o, wake_o, er, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  press, pol, pins, es, pe;
    int          mismatches, samples_checked, cycles, seed, j;

    kpi_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .key_input_pin(pins), .irq_o(irq_o), .wake_o(wake_o));
    kpi_keys keys (.pclk(pclk), .press(press), .pol(pol), .slow(slow), .pin(pins));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] exp_sc(input logic mode, input logic ie, input logic flag);
        return {4'h0, flag, 1'b0, ie, mode};
    endfunction

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, rd, er);
        check("write err", {31'h0, er}, 32'h0);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] e, input string what);
        xfer(1'b0, a, 8'h00, rd, er);
        check(what, rd, {24'h0, e});
        check({what, " err"}, {31'h0, er}, 32'h0);
    endtask

    task automatic settle();
        repeat (8) @(posedge pclk);
    endtask

    task automatic init_cfg(input logic mode, input logic [7:0] e, input logic [7:0] p);
        wr(A_SC, {7'h0, mode});
        wr(A_PE, 8'h00);
        wr(A_ES, e);
        pol   <= e;
        press <= 8'h00;
        settle();
        wr(A_PE, p);
        wr(A_ST, 8'hff);
        wr(A_SC, M_ACK | {7'h0, mode});
        wr(A_SC, M_IE | {7'h0, mode});
    endtask

    initial begin
        seed = 32'hdd25f298;
        {presetn, psel, penable, pwrite, slow} = 5'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        press = 8'h00;
        pol = 8'h00;
        {mismatches, samples_checked, cycles} = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(A_SC, 8'h00, "sc reset");
        rchk(A_PE, 8'h00, "pe reset");
        rchk(A_ES, 8'h00, "es reset");
        rchk(A_MK, 8'h00, "mask reset");
        wr(A_SC, 8'hff);
        rchk(A_SC, exp_sc(1'b1, 1'b1, 1'b0), "sc write all ones");
        wr(A_SC, 8'h00);
        pe = 8'($random(seed));
        wr(A_ES, pe);
        rchk(A_ES, pe, "es readback");
        wr(A_ES, 8'h00);
        wr(A_PE, pe);
        rchk(A_PE, pe, "pe readback");
        xfer(1'b1, 12'h300, 8'h5a, rd, er);
        check("unmapped write err", {31'h0, er}, 32'h1);
        xfer(1'b0, 12'h300, 8'h00, rd, er);
        check("unmapped read", rd, 32'h0);
        xfer(1'b0, A_SC | 12'h001, 8'h00, rd, er);
        check("misaligned err", {31'h0, er}, 32'h1);
        // Every pin alone, random polarity but falling on pin 0, a disabled neighbour toggling
        for (int i = 0; i < 8; i++) begin
            es = 8'($random(seed));
            if (i == 0)
                es[0] = 1'b0;
            pe = 8'h01 << i;
            j = (i + 1) % 8;
            slow <= i[0];
            init_cfg(1'b0, es, pe);
            press <= 8'h01 << j;
            settle();
            rchk(A_SC, exp_sc(1'b0, 1'b1, 1'b0), "disabled pin");
            press <= pe;
            settle();
            rchk(A_SC, exp_sc(1'b0, 1'b1, 1'b1), "edge flag");
            check("irq on edge", {31'h0, irq_o}, 32'h1);
            rchk(A_ST, pe, "pin status");
            press <= 8'h00;
            settle();
            wr(A_SC, M_ACK | M_IE);
            rchk(A_SC, exp_sc(1'b0, 1'b1, 1'b0), "ack clears");
            check("irq after ack", {31'h0, irq_o}, 32'h0);
        end
        slow <= 1'b0;
        // Lockout until every enabled pin is released
        init_cfg(1'b0, 8'h00, 8'h03);
        press <= 8'h01;
        settle();
        wr(A_SC, M_ACK | M_IE);
        press <= 8'h03;
        settle();
        rchk(A_SC, exp_sc(1'b0, 1'b1, 1'b0), "locked out");
        press <= 8'h00;
        settle();
        press <= 8'h02;
        settle();
        rchk(A_SC, exp_sc(1'b0, 1'b1, 1'b1), "rearmed");
        check("wake", {31'h0, wake_o}, 32'h1);
        wr(A_SC, 8'h00);
        rchk(A_SC, exp_sc(1'b0, 1'b0, 1'b1), "flag kept masked");
        check("irq masked", {31'h0, irq_o}, 32'h0);
        check("wake masked", {31'h0, wake_o}, 32'h0);
        // Per-pin status through its mask
        wr(A_ST, 8'hff);
        wr(A_MK, 8'h02);
        press <= 8'h00;
        settle();
        press <= 8'h02;
        settle();
        rchk(A_ST, 8'h02, "status set");
        check("irq via mask", {31'h0, irq_o}, 32'h1);
        press <= 8'h00;
        settle();
        wr(A_ST, 8'h02);
        rchk(A_ST, 8'h00, "status cleared");
        check("irq unmasked off", {31'h0, irq_o}, 32'h0);
        wr(A_MK, 8'h00);
        // Level mode holds the flag while a pin stays asserted
        init_cfg(1'b1, 8'h01, 8'h01);
        press <= 8'h01;
        settle();
        wr(A_SC, 8'h01 | M_ACK | M_IE);
        rchk(A_SC, exp_sc(1'b1, 1'b1, 1'b1), "level hold");
        press <= 8'h00;
        settle();
        wr(A_SC, 8'h01 | M_ACK | M_IE);
        rchk(A_SC, exp_sc(1'b1, 1'b1, 1'b0), "level cleared");
        print_verdict();
    end
endmodule
`default_nettype wire
